// File: rtl/fmi_pkg.sv
/*
 * Constants and types for the file-register move/increment datapath.
 * Assumes a 14-bit instruction word and 8-bit data memory in the core.
 */
package fmi_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int INSN_W = 14;
    // Field positions in the instruction word
    localparam int DEST_BIT = 7;
    localparam int ADDR_LSB = 0;
    localparam int LIT_LSB = 0;
    // Opcode patterns, low bits masked
    localparam logic [5:0] OPC_INC6 = 6'h0A;
    localparam logic [5:0] OPC_IOR6 = 6'h04;
    localparam logic [5:0] OPC_MOVE6 = 6'h08;
    localparam logic [6:0] OPC_STORE7 = 7'h01;
    localparam logic [3:0] OPC_LIT4 = 4'h3;
    localparam logic [13:0] OPC_NOP = 14'h0000;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic ZERO_RESET = 1'h0;

    typedef enum logic [2:0] {
        FMI_OP_NONE = 3'b000,
        FMI_OP_INC = 3'b001,
        FMI_OP_IOR = 3'b010,
        FMI_OP_MOVE = 3'b011,
        FMI_OP_STORE = 3'b100,
        FMI_OP_LIT = 3'b101
    } fmi_op_t;
endpackage

// File: rtl/fmi_decode.sv
/*
 * Instruction decoder for the move/increment group.
 * Assumes an instruction word valid in the cycle it is presented.
 */
`timescale 1ns/1ps
module fmi_decode (
    input wire logic [13:0] insn_i,
    output fmi_pkg::fmi_op_t op_o,
    output logic dest_file_o,
    output logic [6:0] addr_o,
    output logic [7:0] literal_o
);
    always_comb begin
        op_o = fmi_pkg::FMI_OP_NONE;
        if (insn_i[13:8] == fmi_pkg::OPC_INC6) begin
            op_o = fmi_pkg::FMI_OP_INC;
        end else if (insn_i[13:8] == fmi_pkg::OPC_IOR6) begin
            op_o = fmi_pkg::FMI_OP_IOR;
        end else if (insn_i[13:8] == fmi_pkg::OPC_MOVE6) begin
            op_o = fmi_pkg::FMI_OP_MOVE;
        end else if (insn_i[13:7] == fmi_pkg::OPC_STORE7) begin
            op_o = fmi_pkg::FMI_OP_STORE;
        end else if (insn_i[13:10] == fmi_pkg::OPC_LIT4) begin
            // Bits 9:8 ignored; software is expected to keep them zero
            op_o = fmi_pkg::FMI_OP_LIT;
        end
    end
    assign dest_file_o = insn_i[fmi_pkg::DEST_BIT];
    assign addr_o = insn_i[fmi_pkg::ADDR_LSB +: fmi_pkg::ADDR_W];
    assign literal_o = insn_i[fmi_pkg::LIT_LSB +: fmi_pkg::DATA_W];
endmodule

// File: rtl/fmi_datapath.sv
/*
 * Execution datapath for increment, OR, move, store and load-literal.
 * Assumes data memory read is combinational on mem_addr_o and a write
 * is taken on the clock edge while mem_we_o is high. One insn per cycle.
 */
`timescale 1ns/1ps
// Overview of operation
// - Increment addressed file, address 0 to 127
// - Target bit 0 writes accumulator, 1 writes file
// - OR accumulator with file, route, update zero
// - Move file to chosen target, update zero
// - Move back to file tests for zero
// - Store accumulator to file, flags unchanged
// - Load literal to accumulator, flags unchanged
module fmi_datapath #(
    parameter int DATA_W = fmi_pkg::DATA_W,
    parameter int ADDR_W = fmi_pkg::ADDR_W
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic insn_valid_i,
    input wire logic [13:0] insn_i,
    input wire logic [DATA_W-1:0] mem_rdata_i,
    output logic [ADDR_W-1:0] mem_addr_o,
    output logic [DATA_W-1:0] mem_wdata_o,
    output logic mem_we_o,
    output logic [DATA_W-1:0] accum_o,
    output logic zero_flag_o
);
    // Logic below is sized for one data byte and 128 file registers
    if (DATA_W != 8 || ADDR_W != 7) begin : g_bad_width
        $error("fmi_datapath serves only 8-bit data and 7-bit addresses");
    end

    // ****************************************
    // Decode
    // ****************************************
    fmi_pkg::fmi_op_t op;
    logic dest_file;
    logic [6:0] addr;
    logic [7:0] literal;

    fmi_decode u_decode (
        .insn_i(insn_i),
        .op_o(op),
        .dest_file_o(dest_file),
        .addr_o(addr),
        .literal_o(literal)
    );

    // ****************************************
    // Result and routing
    // ****************************************
    logic [DATA_W-1:0] acc_q, acc_d;
    logic zero_q, zero_d;
    logic [DATA_W-1:0] result;
    logic affects_zero;
    logic writes_file;
    logic writes_acc;

    function automatic logic is_zero(input logic [7:0] v);
        return v == 8'h00;
    endfunction

    always_comb begin
        result = mem_rdata_i;
        affects_zero = 1'b0;
        writes_file = 1'b0;
        writes_acc = 1'b0;
        if (insn_valid_i) begin
            unique case (op)
                fmi_pkg::FMI_OP_INC: begin
                    result = DATA_W'(mem_rdata_i + 1'b1);
                    affects_zero = 1'b1;
                    writes_file = dest_file;
                    writes_acc = !dest_file;
                end
                fmi_pkg::FMI_OP_IOR: begin
                    result = acc_q | mem_rdata_i;
                    affects_zero = 1'b1;
                    writes_file = dest_file;
                    writes_acc = !dest_file;
                end
                fmi_pkg::FMI_OP_MOVE: begin
                    // Write-back of same value leaves file unchanged
                    result = mem_rdata_i;
                    affects_zero = 1'b1;
                    writes_file = dest_file;
                    writes_acc = !dest_file;
                end
                fmi_pkg::FMI_OP_STORE: begin
                    result = acc_q;
                    writes_file = 1'b1;
                end
                fmi_pkg::FMI_OP_LIT: begin
                    result = literal;
                    writes_acc = 1'b1;
                end
                fmi_pkg::FMI_OP_NONE: begin
                    result = mem_rdata_i;
                end
            endcase
        end
    end

    always_comb begin
        acc_d = writes_acc ? result : acc_q;
        zero_d = affects_zero ? is_zero(result) : zero_q;
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            acc_q <= fmi_pkg::ACC_RESET;
            zero_q <= fmi_pkg::ZERO_RESET;
        end else begin
            acc_q <= acc_d;
            zero_q <= zero_d;
        end
    end

    // Memory port is combinational; the write lands on the edge that ends the cycle
    assign mem_addr_o = addr;
    assign mem_wdata_o = result;
    assign mem_we_o = writes_file;
    assign accum_o = acc_q;
    assign zero_flag_o = zero_q;

    // ****************************************
    // Checks
    // ****************************************
    a_inc_result: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        insn_valid_i && op == fmi_pkg::FMI_OP_INC && !dest_file
        |=> acc_q == DATA_W'($past(mem_rdata_i) + 1'b1))
        else $error("increment result wrong");
    a_dest_file_write: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        insn_valid_i && dest_file && op inside {fmi_pkg::FMI_OP_INC, fmi_pkg::FMI_OP_IOR}
        |-> mem_we_o ##1 $stable(acc_q))
        else $error("file target not honoured");
    a_or_result: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        insn_valid_i && op == fmi_pkg::FMI_OP_IOR && !dest_file
        |=> acc_q == ($past(acc_q) | $past(mem_rdata_i)))
        else $error("or result wrong");
    a_move_to_acc: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        insn_valid_i && op == fmi_pkg::FMI_OP_MOVE && !dest_file
        |=> acc_q == $past(mem_rdata_i))
        else $error("move to accumulator wrong");
    a_move_test: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        insn_valid_i && op == fmi_pkg::FMI_OP_MOVE && dest_file
        |-> mem_we_o && mem_wdata_o == mem_rdata_i)
        else $error("register test altered value");
    a_store_flags: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        insn_valid_i && op == fmi_pkg::FMI_OP_STORE
        |-> mem_we_o && mem_wdata_o == acc_q ##1 $stable(zero_q))
        else $error("store wrong or flag changed");
    a_literal_load: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        insn_valid_i && op == fmi_pkg::FMI_OP_LIT
        |=> acc_q == $past(literal) && $stable(zero_q))
        else $error("literal load wrong");
    a_zero_flag: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        insn_valid_i && op inside {fmi_pkg::FMI_OP_INC, fmi_pkg::FMI_OP_IOR,
        fmi_pkg::FMI_OP_MOVE} |=> zero_q == ($past(result) == 8'h00))
        else $error("zero flag mismatch");

    // ****************************************
    // Checks on strobe and state changes
    // ****************************************
    // Strobe checks are same-cycle, state checks next-cycle; the memory takes the write on the edge
    a_refused_idle: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !insn_valid_i || op == fmi_pkg::FMI_OP_NONE
        |-> !mem_we_o ##1 ($stable(acc_q) && $stable(zero_q)))
        else $error("idle cycle changed state");
    a_inc_to_file: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        insn_valid_i && op == fmi_pkg::FMI_OP_INC && dest_file
        |-> mem_wdata_o == DATA_W'(mem_rdata_i + 1'b1))
        else $error("increment write data wrong");
    a_or_to_file: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        insn_valid_i && op == fmi_pkg::FMI_OP_IOR && dest_file
        |-> mem_wdata_o == (acc_q | mem_rdata_i))
        else $error("or write data wrong");
    a_acc_target_only: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        insn_valid_i && !dest_file && op inside {fmi_pkg::FMI_OP_INC, fmi_pkg::FMI_OP_IOR,
        fmi_pkg::FMI_OP_MOVE} |-> !mem_we_o)
        else $error("accumulator target wrote memory");
    a_move_test_keep: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        insn_valid_i && op == fmi_pkg::FMI_OP_MOVE && dest_file
        |=> $stable(acc_q) && zero_q == ($past(mem_rdata_i) == 8'h00))
        else $error("register test flag wrong");
    a_move_acc_zero: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        insn_valid_i && op == fmi_pkg::FMI_OP_MOVE && !dest_file
        |=> zero_q == ($past(mem_rdata_i) == 8'h00))
        else $error("move flag wrong");
    a_or_acc_zero: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        insn_valid_i && op == fmi_pkg::FMI_OP_IOR && !dest_file
        |=> zero_q == (($past(acc_q) | $past(mem_rdata_i)) == 8'h00))
        else $error("or flag wrong");
    a_store_keep_acc: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        insn_valid_i && op == fmi_pkg::FMI_OP_STORE
        |=> $stable(acc_q))
        else $error("store changed accumulator");
    a_literal_no_write: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        insn_valid_i && op == fmi_pkg::FMI_OP_LIT
        |-> !mem_we_o)
        else $error("literal load wrote memory");
    a_addr_follow: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        mem_addr_o == insn_i[fmi_pkg::ADDR_LSB +: fmi_pkg::ADDR_W])
        else $error("memory address wrong");
    a_we_needs_insn: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        mem_we_o |-> insn_valid_i && op inside {fmi_pkg::FMI_OP_INC, fmi_pkg::FMI_OP_IOR,
        fmi_pkg::FMI_OP_MOVE, fmi_pkg::FMI_OP_STORE})
        else $error("write strobe without writing insn");
    // Changes of registered state must trace back to an accepted insn
    a_acc_change_cause: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        $changed(acc_q) |-> $past(writes_acc))
        else $error("accumulator changed without cause");
    a_zero_change_cause: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        $changed(zero_q) |-> $past(affects_zero))
        else $error("zero flag changed without cause");
    a_inc_wrap_zero: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        insn_valid_i && op == fmi_pkg::FMI_OP_INC && mem_rdata_i == 8'hFF
        |=> zero_q)
        else $error("increment wrap did not set zero");
endmodule

// File: sim/file_register_move_or_increment_test.sv
/*
 * Self-checking bench for the file-register move/increment datapath.
 * Assumes the datapath top with combinational memory outputs and
 * registered accumulator and zero flag; the bench acts as data memory.
 */
`timescale 1ns/1ps
module file_register_move_or_increment_test;
    typedef struct packed {
        logic we;
        logic [7:0] wd;
        logic [6:0] ad;
        logic [7:0] acc;
        logic z;
    } fmi_note_t;
    logic sys_clk_i = 1'h0;
    logic reset_i = 1'h1;
    logic insn_valid_i = 1'h0;
    logic [13:0] insn_i = 14'h0000;
    logic [7:0] mem_rdata_i;
    logic [6:0] mem_addr_o;
    logic [7:0] mem_wdata_o;
    logic mem_we_o;
    logic [7:0] accum_o;
    logic zero_flag_o;
    logic [7:0] mem [128];
    logic [7:0] ref_mem [128];
    logic [7:0] ref_acc = fmi_pkg::ACC_RESET;
    logic ref_z = fmi_pkg::ZERO_RESET;
    fmi_note_t notes[$];
    fmi_note_t prev;
    logic have_prev = 1'h0;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [13:0] dir [13] = '{14'h0C00, 14'h08FF, 14'h0F5A, 14'h0A05, 14'h0A85, 14'h047F,
        14'h0C4F, 14'h00FF, 14'h087F, 14'h3F00, 14'h0000, 14'h0480, 14'h0A00};

    always #2 sys_clk_i = ~sys_clk_i;
    assign mem_rdata_i = mem[mem_addr_o];
    always @(posedge sys_clk_i) if (mem_we_o === 1'h1) mem[mem_addr_o] <= mem_wdata_o;

    fmi_datapath i_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .insn_valid_i(insn_valid_i),
        .insn_i(insn_i), .mem_rdata_i(mem_rdata_i), .mem_addr_o(mem_addr_o),
        .mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o), .accum_o(accum_o),
        .zero_flag_o(zero_flag_o));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Reference model runs beside the drive; memory writes go to ref_mem only
    task automatic run(input logic v, input logic [13:0] w);
        fmi_note_t n;
        logic [7:0] f;
        logic [7:0] r;
        logic alu;
        f = ref_mem[w[6:0]];
        alu = 1'h0;
        r = 8'h00;
        n = '{1'h0, 8'h00, w[6:0], 8'h00, 1'h0};
        @(posedge sys_clk_i);
        #1;
        insn_valid_i = v;
        insn_i = w;
        if (v) casez (w)
            14'b00_1010_????_????: {alu, r} = {1'h1, f + 8'h01};
            14'b00_0100_????_????: {alu, r} = {1'h1, ref_acc | f};
            14'b00_1000_????_????: {alu, r} = {1'h1, f};
            14'b00_0000_1???_????: begin
                {n.we, n.wd, ref_mem[w[6:0]]} = {1'h1, ref_acc, ref_acc};
            end
            14'b00_11??_????_????: ref_acc = w[7:0];
            default: ;
        endcase
        if (alu) begin
            ref_z = (r == 8'h00);
            if (w[7]) {n.we, n.wd, ref_mem[w[6:0]]} = {1'h1, r, r};
            else ref_acc = r;
        end
        n.acc = ref_acc;
        n.z = ref_z;
        notes.push_back(n);
    endtask

    // Mid-cycle: memory strobe of the current insn, state left by the previous one
    always @(negedge sys_clk_i) begin
        if (have_prev) begin
            check(accum_o, prev.acc);
            check({7'h00, zero_flag_o}, {7'h00, prev.z});
        end
        have_prev = 1'h0;
        if (notes.size() > 0) begin
            prev = notes.pop_front();
            have_prev = 1'h1;
            check({7'h00, mem_we_o}, {7'h00, prev.we});
            if (prev.we) check(mem_wdata_o, prev.wd);
            check({1'h0, mem_addr_o}, {1'h0, prev.ad});
        end
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end

    initial begin
        void'($urandom(48584));
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'($urandom());
            ref_mem[i] = mem[i];
        end
        {mem[0], mem[5], mem[127]} = {8'h80, 8'hFF, 8'h00};
        {ref_mem[0], ref_mem[5], ref_mem[127]} = {8'h80, 8'hFF, 8'h00};
        repeat (20) @(posedge sys_clk_i);
        #1;
        reset_i = 1'h0;
        check(accum_o, fmi_pkg::ACC_RESET);
        check({7'h00, zero_flag_o}, {7'h00, fmi_pkg::ZERO_RESET});
        // Boundary cases: wrap to zero, addresses 0 and 127, flags kept
        foreach (dir[i]) run(1'h1, dir[i]);
        run(1'h0, 14'h0A80);
        $display("directed sequence done");
        for (int i = 0; i < 1500; i++) begin
            logic [6:0] a;
            logic d;
            a = 7'($urandom());
            d = 1'($urandom());
            case ($urandom_range(0, 6))
                0: run(1'h1, {6'h0A, d, a});
                1: run(1'h1, {6'h04, d, a});
                2: run(1'h1, {6'h08, d, a});
                3: run(1'h1, {7'h01, a});
                4: run(1'h1, {4'h3, 2'($urandom()), 8'($urandom())});
                5: run(1'h0, {6'h0A, d, a});
                default: run(1'h1, 14'h0000);
            endcase
        end
        $display("random sequence done");
        run(1'h0, 14'h0000);
        repeat (3) @(negedge sys_clk_i);
        print_verdict();
    end
endmodule
